// ### shared/fpm_regs.svh
`ifndef FPM_REGS_SVH
`define FPM_REGS_SVH
// Register offsets (word index on the plain port)
`define FPM_ADDR_PACK_CONFIGURATION_REGISTER   4'h0
`define FPM_ADDR_SCANCFG   4'h1
`define FPM_ADDR_STATUS    4'h2
`define FPM_ADDR_MASK      4'h3
`define FPM_ADDR_ROUTE     4'h4
// Pack and scan configuration field positions
`define FPM_PC_SELA_LSB    0
`define FPM_PC_SELB_LSB    4
`define FPM_PC_BLK_LSB     8
`define FPM_PC_ENA_BIT     12
`define FPM_PC_ENB_BIT     13
`define FPM_SC_SCAN_BIT    0
// Status bit positions
`define FPM_ST_FAULT_BIT   0
`define FPM_ST_MISM_BIT    1
`define FPM_ST_SETTLE_BIT  2
// Reset values, select off code and minimum select
`define FPM_RST_SEL        4'hF
`define FPM_RST_BLK        4'hF
`define FPM_RST_EN         1'b1
`define FPM_SEL_OFF        4'hF
`define FPM_SEL_MIN        4'h8
// Settling time
`define FPM_SETTLE_NS      30000
`define FPM_CLK_NS         10
`define FPM_SETTLE_CYC     (`FPM_SETTLE_NS / `FPM_CLK_NS)
`endif

// ### shared/fpm_pkg.sv
package fpm_pkg;
    typedef logic [3:0]  fpm_sel_t;
    typedef logic [15:0] fpm_word_t;
    typedef enum logic [1:0] {
        FPM_IDLE   = 2'b00,
        FPM_ISOL   = 2'b01,
        FPM_CONV   = 2'b10
    } fpm_state_e;
endpackage

// ### design/fpm_settle_timer.sv
`timescale 1ns/10ps
`include "fpm_regs.svh"
// Counts the top-cell settling delay after isolation
module fpm_settle_timer
    import fpm_pkg::*;
(
    // Clock, reset and enable
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    // Control
    input  wire logic i_start,
    output logic      o_done
);
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(`FPM_SETTLE_CYC - 1);
    logic [CNT_W-1:0] cnt_r;
    logic             run_r;

    // Load on start, pulse done on last count
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r  <= '0;
            run_r  <= 1'b0;
            o_done <= 1'b0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            if (i_start) begin
                cnt_r <= '0;
                run_r <= 1'b1;
            end else if (run_r) begin
                if (cnt_r == LAST) begin
                    run_r  <= 1'b0;
                    o_done <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + CNT_W'(1);
                end
            end
        end
    end
endmodule

// ### design/fpm_power_mux_ctrl.sv
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "fpm_regs.svh"
module fpm_power_mux_ctrl
    import fpm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    // Register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    // Acquisition handshake
    input  wire logic        i_top_conv_req,
    input  wire logic        i_alt_path,
    output logic             o_top_conv_go,
    // Supply mux health
    input  wire logic        i_mux_fault,
    input  wire logic        i_alert_reset_indication,
    // Mux controls
    output logic      [6:0]  o_supply_sw,
    output logic      [3:0]  o_block_sel,
    output logic             o_supply_isolate,
    output logic             o_supply_mux_fault_alert,
    output logic             o_irq
);
    // Software-written copies
    fpm_sel_t   sel_a_r, sel_b_r, blk_r;
    logic       en_a_r, en_b_r, scan_r;
    logic [2:0] sts_r, msk_r;
    // Effective decoded values
    logic       mism;
    logic       eff_en;
    fpm_sel_t   eff_sel;
    logic       sel_off;
    fpm_sel_t   blk_dec;
    logic       route_ok;
    logic [6:0] sw_dec;
    // Sequencer
    fpm_state_e st_r;
    logic       tmr_start, tmr_done;
    logic       armed_r;
    logic       fault_ev, settle_ev;

    // Configuration registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sel_a_r <= `FPM_RST_SEL;
            sel_b_r <= `FPM_RST_SEL;
            blk_r   <= `FPM_RST_BLK;
            en_a_r  <= `FPM_RST_EN;
            en_b_r  <= `FPM_RST_EN;
            scan_r  <= 1'b0;
            msk_r   <= '0;
        end else if (i_ce && i_wr) begin
            if (i_addr == `FPM_ADDR_PACK_CONFIGURATION_REGISTER) begin
                sel_a_r <= i_wdata[`FPM_PC_SELA_LSB +: 4];
                sel_b_r <= i_wdata[`FPM_PC_SELB_LSB +: 4];
                blk_r   <= i_wdata[`FPM_PC_BLK_LSB +: 4];
                en_a_r  <= i_wdata[`FPM_PC_ENA_BIT];
                en_b_r  <= i_wdata[`FPM_PC_ENB_BIT];
            end
            if (i_addr == `FPM_ADDR_SCANCFG)
                scan_r <= i_wdata[`FPM_SC_SCAN_BIT];
            if (i_addr == `FPM_ADDR_MASK)
                msk_r <= i_wdata[2:0];
        end
    end

    // Copy check and decode
    always_comb begin
        mism    = (en_a_r != en_b_r) || (sel_a_r != sel_b_r);
        eff_en  = mism ? `FPM_RST_EN : en_a_r;
        eff_sel = mism ? `FPM_RST_SEL : sel_a_r;
        sel_off = (eff_sel < `FPM_SEL_MIN) || (eff_sel == `FPM_SEL_OFF);
        route_ok = eff_en && !sel_off;
        sw_dec  = '0;
        if (route_ok)
            sw_dec = 7'(7'h01 << eff_sel[2:0]);
        blk_dec = blk_r;
        if (blk_r < `FPM_SEL_MIN || !route_ok)
            blk_dec = `FPM_RST_BLK;
    end

    assign fault_ev  = i_mux_fault && route_ok && armed_r;
    assign settle_ev = tmr_done;
    assign tmr_start = i_ce && (st_r == FPM_IDLE) && i_top_conv_req && i_alt_path && scan_r && route_ok;

    // Top-cell conversion sequencer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r             <= FPM_IDLE;
            o_top_conv_go    <= 1'b0;
            o_supply_isolate <= 1'b0;
        end else if (i_ce) begin
            o_top_conv_go <= 1'b0;
            unique case (st_r)
                FPM_IDLE: begin
                    if (i_top_conv_req) begin
                        if (tmr_start) begin
                            st_r             <= FPM_ISOL;
                            o_supply_isolate <= 1'b1;
                        end else begin
                            o_top_conv_go <= 1'b1;
                            st_r          <= FPM_CONV;
                        end
                    end
                end
                FPM_ISOL: begin
                    if (tmr_done) begin
                        o_top_conv_go <= 1'b1;
                        st_r          <= FPM_CONV;
                    end
                end
                FPM_CONV: begin
                    if (!i_top_conv_req) begin
                        o_supply_isolate <= 1'b0;
                        st_r             <= FPM_IDLE;
                    end
                end
                default: st_r <= FPM_IDLE;
            endcase
        end
    end

    fpm_settle_timer u_timer (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_start (tmr_start),
        .o_done  (tmr_done)
    );

    // Alert arming after first clear of alert-reset
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst)
            armed_r <= 1'b0;
        else if (i_ce && !i_alert_reset_indication)
            armed_r <= 1'b1;
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sts_r <= '0;
        end else if (i_ce) begin
            logic [2:0] clr;
            clr = (i_wr && i_addr == `FPM_ADDR_STATUS) ? i_wdata[2:0] : 3'h0;
            sts_r <= (sts_r & ~clr) | {settle_ev, mism, fault_ev};
        end
    end

    // Registered outputs
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_supply_sw              <= '0;
            o_block_sel              <= `FPM_RST_BLK;
            o_supply_mux_fault_alert <= 1'b0;
            o_irq                    <= 1'b0;
        end else if (i_ce) begin
            o_supply_sw              <= (st_r == FPM_ISOL || tmr_start) ? 7'h00 : sw_dec;
            o_block_sel              <= blk_dec;
            o_supply_mux_fault_alert <= fault_ev;
            o_irq                    <= |(sts_r & msk_r);
        end
    end

    // Read data, one cycle later
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_ce) begin
            o_rdata <= '0;
            if (i_rd) begin
                unique case (i_addr)
                    `FPM_ADDR_PACK_CONFIGURATION_REGISTER: o_rdata <= {2'b00, en_b_r, en_a_r, blk_r, sel_b_r, sel_a_r};
                    `FPM_ADDR_SCANCFG: o_rdata <= {15'h0000, scan_r};
                    `FPM_ADDR_STATUS:  o_rdata <= {13'h0000, sts_r};
                    `FPM_ADDR_MASK:    o_rdata <= {13'h0000, msk_r};
                    `FPM_ADDR_ROUTE:   o_rdata <= {3'b000, route_ok, blk_dec, 1'b0, o_supply_sw};
                    default:           o_rdata <= '0;
                endcase
            end
        end
    end

    // Checks
    property p_mism_off;
        @(posedge i_clk) disable iff (i_rst) (i_ce && mism) |=> (o_supply_sw == 7'h00) || !$past(i_ce);
    endproperty
    a_mism_off: assert property (p_mism_off) else $error("mismatch did not give default");
    property p_low_off;
        @(posedge i_clk) disable iff (i_rst) (i_ce && sel_a_r < 4'h8 && !mism) |=> o_supply_sw == 7'h00;
    endproperty
    a_low_off: assert property (p_low_off) else $error("low select not off");
    property p_blk;
        @(posedge i_clk) disable iff (i_rst) (i_ce && blk_r < 4'h8) |=> o_block_sel == 4'hF;
    endproperty
    a_blk: assert property (p_blk) else $error("block select not remapped");
    property p_blk_route;
        @(posedge i_clk) disable iff (i_rst) (i_ce && !route_ok) |=> o_block_sel == 4'hF;
    endproperty
    a_blk_route: assert property (p_blk_route) else $error("divider routed too early");
    property p_iso;
        @(posedge i_clk) disable iff (i_rst) (st_r == FPM_ISOL) |-> o_supply_sw == 7'h00;
    endproperty
    a_iso: assert property (p_iso) else $error("switch closed during isolation");
    property p_nowait;
        @(posedge i_clk) disable iff (i_rst) (i_ce && st_r == FPM_IDLE && i_top_conv_req && !i_alt_path) |=> o_top_conv_go;
    endproperty
    a_nowait: assert property (p_nowait) else $error("primary path delayed");
    property p_unarmed;
        @(posedge i_clk) disable iff (i_rst) !armed_r |=> !o_supply_mux_fault_alert;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("alert before arming");
    property p_alert;
        @(posedge i_clk) disable iff (i_rst) (i_ce && fault_ev) |=> o_supply_mux_fault_alert;
    endproperty
    a_alert: assert property (p_alert) else $error("alert missed");
    c_iso: cover property (@(posedge i_clk) disable iff (i_rst) st_r == FPM_ISOL ##1 o_top_conv_go);
    c_mism: cover property (@(posedge i_clk) disable iff (i_rst) mism);
    c_alert: cover property (@(posedge i_clk) disable iff (i_rst) o_supply_mux_fault_alert);
endmodule

// ### bench/fpm_power_mux_ctrl_tb.sv
`timescale 1ns/10ps
`include "fpm_regs.svh"
module fpm_power_mux_ctrl_tb;
    import fpm_pkg::*;
    logic        i_clk = 0, i_rst = 1, i_ce = 1, i_wr = 0, i_rd = 0;
    logic [3:0]  i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_top_conv_req = 0, i_alt_path = 0, i_mux_fault = 0, i_alert_reset_indication = 1;
    logic [15:0] o_rdata, rv, pc, d;
    logic        o_top_conv_go, o_supply_isolate, o_supply_mux_fault_alert, o_irq;
    logic [6:0]  o_supply_sw;
    logic [3:0]  o_block_sel;
    logic [31:0] seed = 32'hD06A1B60;
    int          err_total = 0, comparisons = 0, cyc = 0, c;
    logic [15:0] corner [6] = '{16'h3888, 16'h3E77, 16'h30EE, 16'h1EEE, 16'h3E8E, 16'h2DDD};

    fpm_power_mux_ctrl i_fpm_power_mux_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_top_conv_req(i_top_conv_req),
        .i_alt_path(i_alt_path), .o_top_conv_go(o_top_conv_go), .i_mux_fault(i_mux_fault),
        .i_alert_reset_indication(i_alert_reset_indication), .o_supply_sw(o_supply_sw),
        .o_block_sel(o_block_sel), .o_supply_isolate(o_supply_isolate),
        .o_supply_mux_fault_alert(o_supply_mux_fault_alert), .o_irq(o_irq));

    // Free-running clock
    always #5 i_clk = ~i_clk;

    // Hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected route readback: {ok, block select, switch one-hot}
    function automatic logic [15:0] exp_route(input logic [15:0] p);
        logic       ok;
        logic [3:0] b;
        ok = (p[13:12] == 2'b11) && (p[3:0] == p[7:4]) && (p[3:0] >= 4'h8) && (p[3:0] != 4'hF);
        b = (ok && p[11:8] >= 4'h8) ? p[11:8] : 4'hF;
        return {3'b000, ok, b, 1'b0, ok ? 7'(7'h01 << (p[3:0] - 4'h8)) : 7'h00};
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask

    // Top-cell conversion request, returns cycles until go
    task automatic conv(input logic alt, output int n);
        @(posedge i_clk);
        i_alt_path <= alt;
        i_top_conv_req <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
            #1;
            if (n == 5) chk({o_supply_isolate, o_supply_sw}, 16'h0080);
        end while (o_top_conv_go !== 1'b1 && n < 4000);
        @(posedge i_clk);
        i_top_conv_req <= 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge i_clk);
        chk({o_block_sel, 5'h00, o_supply_sw}, 16'hF000);
        i_rst <= 1'b0;
        rd(`FPM_ADDR_PACK_CONFIGURATION_REGISTER, d);
        chk(d, 16'h3FFF);
        rd(`FPM_ADDR_SCANCFG, d);
        chk(d, 16'h0000);
        rd(4'h9, d);
        chk(d, 16'h0000);
        // Corner codes, then random configurations
        for (int k = 0; k < 30; k++) begin
            rv = xs();
            pc = {2'b00, rv[14] ? rv[13:12] : 2'b11, rv[11:8], rv[15] ? rv[7:4] : rv[3:0], rv[3:0]};
            if (k < 6) pc = corner[k];
            wr(`FPM_ADDR_PACK_CONFIGURATION_REGISTER, pc);
            rv = exp_route(pc);
            repeat (3) @(posedge i_clk);
            #1 chk({o_block_sel, 5'h00, o_supply_sw}, {rv[11:8], 5'h00, rv[6:0]});
            rd(`FPM_ADDR_ROUTE, d);
            chk(d, rv);
            chk(rv[12] ? 16'h0000 : {9'h000, d[6:0]}, 16'h0000);
        end
        // Copy mismatch latched in status, seen on the interrupt
        wr(`FPM_ADDR_MASK, 16'h0002);
        wr(`FPM_ADDR_PACK_CONFIGURATION_REGISTER, 16'h3E8E);
        repeat (2) @(posedge i_clk);
        #1 chk(16'(o_irq), 16'h0001);
        wr(`FPM_ADDR_PACK_CONFIGURATION_REGISTER, 16'h3EEE);
        wr(`FPM_ADDR_STATUS, 16'h0007);
        repeat (2) @(posedge i_clk);
        #1 chk(16'(o_irq), 16'h0000);
        // Conversions with scan isolation on, then off
        wr(`FPM_ADDR_SCANCFG, 16'h0001);
        conv(1'b0, c);
        chk(16'(c <= 2), 16'h0001);
        conv(1'b1, c);
        chk(16'(c >= 3000 && c <= 3005), 16'h0001);
        repeat (3) @(posedge i_clk);
        #1 chk({o_supply_isolate, o_supply_sw}, 16'h0040);
        wr(`FPM_ADDR_SCANCFG, 16'h0000);
        conv(1'b1, c);
        chk(16'(c <= 2), 16'h0001);
        // Fault alert held off until alert-reset clears
        wr(`FPM_ADDR_MASK, 16'h0001);
        i_mux_fault <= 1'b1;
        repeat (10) @(posedge i_clk);
        #1 chk({o_supply_mux_fault_alert, o_irq}, 16'h0000);
        @(posedge i_clk);
        i_alert_reset_indication <= 1'b0;
        repeat (5) @(posedge i_clk);
        #1 chk({o_supply_mux_fault_alert, o_irq}, 16'h0003);
        @(posedge i_clk);
        i_mux_fault <= 1'b0;
        wr(`FPM_ADDR_STATUS, 16'h0001);
        repeat (3) @(posedge i_clk);
        #1 chk(16'(o_irq), 16'h0000);
        tally_and_finish();
    end
endmodule
